// [pkg/gate_cfg_regs.svh]
// Register offsets, field positions, reset values and timing figures
// for the primary-side configuration block.
// Assumes inclusion by bare name from the design and bench files.
`ifndef GATE_CFG_REGS_SVH
`define GATE_CFG_REGS_SVH

// ----------------------------------------------------------------------
// Register offsets (serial port address field)
// ----------------------------------------------------------------------
`define PRIMARY_CONFIG_ADDR 7'h00
`define FAULT_REPORT_CONFIG_ADDR 7'h01

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PRIMARY_CONFIG_RESET 16'h0C00
`define FAULT_REPORT_CONFIG_RESET 16'h0200

// ----------------------------------------------------------------------
// Field positions of primary_config
// ----------------------------------------------------------------------
`define UNDERVOLT_DISABLE_BIT 15
`define UNDERVOLT_LEVEL_BIT 14
`define OVERVOLT_LEVEL_BIT 13
`define DEGLITCH_HI_BIT 12
`define DEGLITCH_LO_BIT 11
`define TEMP_WARNING_OFF_BIT 10
`define OVERVOLT_DISABLE_BIT 8
`define SHARED_PIN_SELECT_BIT 6
`define DEAD_CODE_HI_BIT 5
`define DEAD_CODE_LO_BIT 0

// ----------------------------------------------------------------------
// Serial frame: write flag, 7-bit address, 16-bit data, MSB first
// ----------------------------------------------------------------------
`define FRAME_BITS 24
`define FRAME_WRITE_BIT 23
`define FRAME_HEADER_BITS 8

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define CLK_PERIOD_NS 25
`define DEGLITCH_STEP_NS 70
`define DEAD_STEP_NS 70
`define DEAD_BASE_NS 105

`endif

// [pkg/gate_cfg_pkg.sv]
// Types shared by the primary-side configuration block and its bench.
// Assumes gate_cfg_regs.svh supplies the numeric constants.
package gate_cfg_pkg;

  typedef logic [15:0] reg_word_t;

  typedef logic [5:0] dead_code_t;

  typedef enum logic [1:0] {
    DEGLITCH_BYPASS = 2'b00,
    DEGLITCH_70NS = 2'b01,
    DEGLITCH_140NS = 2'b10,
    DEGLITCH_210NS = 2'b11
  } deglitch_sel_t;

endpackage : gate_cfg_pkg

// [hdl/primary_side_config_regs.sv]
// Primary-side configuration registers with their serial port, input
// deglitch filters, dead-time generator and fault pin steering.
// Assumes all inputs are synchronous to ref_clk and that the serial
// clock is slow enough to be sampled (at most ref_clk / 4).
`timescale 1ns/10ps
`include "gate_cfg_regs.svh"

// Overview of operation
// RULE1 - The undervoltage threshold select is 0 for 2.45V and 1 for 4.35V and resets to 0.
// RULE2 - The overvoltage threshold select is 0 for 5.65V and 1 for 4.15V and resets to 0.
// RULE3 - Both PWM inputs are deglitched for 0, 70, 140 or 210ns by bits 12-11, reset 1.
// RULE4 - Bit 10 low enables the primary over-temperature warning; it resets high.
// RULE5 - Bit 6 makes the shared pin a secondary fault output (0) or serial data out (1).
// RULE6 - With the shared pin as data out, secondary warnings go to the primary fault pin.
// RULE7 - A nonzero dead-time code delays turn-on by code times 70ns plus 105ns.
// RULE8 - A zero dead-time code adds no delay and leaves only input interlock.
// RULE9 - Bits 9 and 7 are plain read/write bits resetting to 0 with no function.
// RULE10 - The host writes the registers only in the permitted configuration state; this block has no such state and commits a write at any time.
// RULE11 - Bits 15 and 8 low enable undervoltage and overvoltage lockout; both reset to 0.
// RULE12 - A read returns the stored fields and leaves them unchanged.
module primary_side_config_regs #(
  parameter int FILTER_CNT_W = 4,
  parameter int DEAD_CNT_W = 8
) (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic spi_sclk,
  input wire logic spi_cs_n,
  input wire logic spi_mosi,
  input wire logic pwm_input_pos,
  input wire logic pwm_input_neg,
  input wire logic primary_fault_req,
  input wire logic secondary_warn_req,
  output logic primary_undervolt_enable,
  output logic primary_undervolt_level,
  output logic primary_overvolt_enable,
  output logic primary_overvolt_level,
  output logic primary_temp_warning_enable,
  output gate_cfg_pkg::reg_word_t fault_report_config,
  output logic gate_on,
  output logic primary_fault_out,
  output logic primary_fault_oe,
  output logic shared_pin_out,
  output logic shared_pin_oe
);
  import gate_cfg_pkg::*;

  // ----------------------------------------------------------------------
  // Elaboration checks
  // ----------------------------------------------------------------------
  localparam int MAX_FILTER_CYC = (3 * `DEGLITCH_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  localparam int MAX_DEAD_CYC =
    (63 * `DEAD_STEP_NS + `DEAD_BASE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS;
  if (MAX_FILTER_CYC >= (1 << FILTER_CNT_W)) begin : g_bad_filter
    $error("FILTER_CNT_W too small for the longest deglitch time");
  end
  if (MAX_DEAD_CYC >= (1 << DEAD_CNT_W)) begin : g_bad_dead
    $error("DEAD_CNT_W too small for the longest dead time");
  end

  // ----------------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ----------------------------------------------------------------------
  // Serial port and registers
  // ----------------------------------------------------------------------
  reg_word_t primary_config;
  reg_word_t fault_cfg;
  logic sclk_prev;
  logic [4:0] bit_cnt;
  logic [`FRAME_BITS-2:0] shift_in;
  reg_word_t shift_out;
  logic miso_bit;
  reg_word_t next_primary_config;
  reg_word_t next_fault_cfg;
  logic [4:0] next_bit_cnt;
  logic [`FRAME_BITS-2:0] next_shift_in;
  reg_word_t next_shift_out;
  logic next_miso_bit;
  logic [`FRAME_BITS-1:0] frame;
  logic [6:0] addr_now;
  reg_word_t read_value;

  always_comb begin
    next_primary_config = primary_config;
    next_fault_cfg = fault_cfg;
    next_bit_cnt = bit_cnt;
    next_shift_in = shift_in;
    next_shift_out = shift_out;
    next_miso_bit = miso_bit;
    frame = {shift_in, spi_mosi};
    addr_now = frame[6:0];
    // Reads return stored values only; nothing is cleared by them
    if (addr_now == `PRIMARY_CONFIG_ADDR) begin // RULE12
      read_value = primary_config;
    end else if (addr_now == `FAULT_REPORT_CONFIG_ADDR) begin
      read_value = fault_cfg;
    end else begin
      read_value = 16'h0000;
    end
    if (spi_cs_n) begin
      next_bit_cnt = 5'h00;
    end else if (spi_sclk && !sclk_prev && bit_cnt < 5'(`FRAME_BITS)) begin
      next_shift_in = frame[`FRAME_BITS-2:0];
      next_bit_cnt = bit_cnt + 5'h01;
      if (bit_cnt == 5'(`FRAME_HEADER_BITS - 1)) begin
        next_shift_out = read_value;
      end
      // Whole frame in: commit a write; bits 9 and 7 are stored like any other
      if (bit_cnt == 5'(`FRAME_BITS - 1) && frame[`FRAME_WRITE_BIT]) begin // RULE9
        if (frame[22:16] == `PRIMARY_CONFIG_ADDR) begin
          next_primary_config = frame[15:0];
        end else if (frame[22:16] == `FAULT_REPORT_CONFIG_ADDR) begin
          next_fault_cfg = frame[15:0];
        end
      end
    end else if (!spi_sclk && sclk_prev && bit_cnt >= 5'(`FRAME_HEADER_BITS)) begin
      next_miso_bit = shift_out[15];
      next_shift_out = {shift_out[14:0], 1'b0};
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      primary_config <= `PRIMARY_CONFIG_RESET; // RULE1 RULE2 RULE11
      fault_cfg <= `FAULT_REPORT_CONFIG_RESET;
      sclk_prev <= 1'b0;
      bit_cnt <= 5'h00;
      shift_in <= '0;
      shift_out <= 16'h0000;
      miso_bit <= 1'b0;
    end else begin
      primary_config <= next_primary_config;
      fault_cfg <= next_fault_cfg;
      sclk_prev <= spi_sclk;
      bit_cnt <= next_bit_cnt;
      shift_in <= next_shift_in;
      shift_out <= next_shift_out;
      miso_bit <= next_miso_bit;
    end
  end

  // ----------------------------------------------------------------------
  // Input deglitch filters
  // ----------------------------------------------------------------------
  deglitch_sel_t deglitch_sel;
  logic [FILTER_CNT_W-1:0] filter_cycles;
  logic [1:0] raw_in;
  logic [1:0] filt_in;
  assign deglitch_sel = deglitch_sel_t'(primary_config[`DEGLITCH_HI_BIT:`DEGLITCH_LO_BIT]);
  assign filter_cycles = FILTER_CNT_W'((int'(deglitch_sel) * `DEGLITCH_STEP_NS
    + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS); // RULE3
  assign raw_in = {pwm_input_neg, pwm_input_pos};

  for (genvar i = 0; i < 2; i++) begin : g_filter
    logic [FILTER_CNT_W-1:0] cnt;
    logic level;
    logic [FILTER_CNT_W-1:0] next_cnt;
    logic next_level;
    always_comb begin
      next_cnt = '0;
      next_level = level;
      if (deglitch_sel == DEGLITCH_BYPASS) begin // RULE3
        next_level = raw_in[i];
      end else if (raw_in[i] != level) begin
        if (cnt >= filter_cycles - FILTER_CNT_W'(1)) begin
          next_level = raw_in[i];
        end else begin
          next_cnt = cnt + FILTER_CNT_W'(1);
        end
      end
    end
    always_ff @(posedge ref_clk or negedge rst_n) begin
      if (!rst_n) begin
        cnt <= '0;
        level <= 1'b0;
      end else begin
        cnt <= next_cnt;
        level <= next_level;
      end
    end
    assign filt_in[i] = level;
  end

  // ----------------------------------------------------------------------
  // Dead-time generator and output registers
  // ----------------------------------------------------------------------
  dead_code_t dead_code;
  logic [DEAD_CNT_W-1:0] dead_cycles;
  logic [DEAD_CNT_W-1:0] dead_cnt;
  logic [DEAD_CNT_W-1:0] next_dead_cnt;
  logic next_gate_on;
  logic pwm_cmd;
  logic shared_sel;
  logic next_undervolt_enable;
  logic next_undervolt_level;
  logic next_overvolt_enable;
  logic next_overvolt_level;
  logic next_temp_warning_enable;
  logic next_fault_oe;
  logic next_shared_out;
  logic next_shared_oe;
  assign dead_code = primary_config[`DEAD_CODE_HI_BIT:`DEAD_CODE_LO_BIT];
  assign dead_cycles = DEAD_CNT_W'((int'(dead_code) * `DEAD_STEP_NS + `DEAD_BASE_NS
    + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS); // RULE7
  // Inverting input blocks the positive one
  assign pwm_cmd = filt_in[0] & ~filt_in[1]; // RULE8
  assign shared_sel = primary_config[`SHARED_PIN_SELECT_BIT];

  always_comb begin
    next_dead_cnt = '0;
    next_gate_on = 1'b0;
    next_undervolt_enable = ~primary_config[`UNDERVOLT_DISABLE_BIT]; // RULE11
    next_undervolt_level = primary_config[`UNDERVOLT_LEVEL_BIT]; // RULE1
    next_overvolt_enable = ~primary_config[`OVERVOLT_DISABLE_BIT]; // RULE11
    next_overvolt_level = primary_config[`OVERVOLT_LEVEL_BIT]; // RULE2
    next_temp_warning_enable = ~primary_config[`TEMP_WARNING_OFF_BIT]; // RULE4
    next_fault_oe = primary_fault_req | (shared_sel & secondary_warn_req); // RULE6
    if (shared_sel) begin // RULE5
      next_shared_out = miso_bit;
      next_shared_oe = ~spi_cs_n;
    end else begin
      next_shared_out = 1'b0;
      next_shared_oe = secondary_warn_req;
    end
    if (pwm_cmd) begin
      if (gate_on || dead_code == 6'h00) begin // RULE8
        next_gate_on = 1'b1;
      end else if (dead_cnt >= dead_cycles - DEAD_CNT_W'(1)) begin // RULE7
        next_gate_on = 1'b1;
      end else begin
        next_dead_cnt = dead_cnt + DEAD_CNT_W'(1);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dead_cnt <= '0;
      gate_on <= 1'b0;
      primary_undervolt_enable <= 1'b1;
      primary_undervolt_level <= 1'b0;
      primary_overvolt_enable <= 1'b1;
      primary_overvolt_level <= 1'b0;
      primary_temp_warning_enable <= 1'b0;
      fault_report_config <= `FAULT_REPORT_CONFIG_RESET;
      primary_fault_out <= 1'b0;
      primary_fault_oe <= 1'b0;
      shared_pin_out <= 1'b0;
      shared_pin_oe <= 1'b0;
    end else begin
      dead_cnt <= next_dead_cnt;
      gate_on <= next_gate_on;
      primary_undervolt_enable <= next_undervolt_enable;
      primary_undervolt_level <= next_undervolt_level;
      primary_overvolt_enable <= next_overvolt_enable;
      primary_overvolt_level <= next_overvolt_level;
      primary_temp_warning_enable <= next_temp_warning_enable;
      fault_report_config <= fault_cfg;
      primary_fault_out <= 1'b0;
      primary_fault_oe <= next_fault_oe;
      shared_pin_out <= next_shared_out;
      shared_pin_oe <= next_shared_oe;
    end
  end

endmodule : primary_side_config_regs

// [bench/cfg_checker_properties.sv]
// Port checker for the primary-side configuration block.
// Assumes it is bound to the design and sees only its ports.
`timescale 1ns/10ps
module cfg_checker (
  input wire logic ref_clk,
  input wire logic nrst,
  input wire logic spi_cs_n,
  input wire logic pwm_input_pos,
  input wire logic pwm_input_neg,
  input wire logic primary_fault_req,
  input wire logic secondary_warn_req,
  input wire logic primary_undervolt_enable,
  input wire logic primary_undervolt_level,
  input wire logic primary_overvolt_enable,
  input wire logic primary_overvolt_level,
  input wire logic primary_temp_warning_enable,
  input wire gate_cfg_pkg::reg_word_t fault_report_config,
  input wire logic gate_on,
  input wire logic primary_fault_oe,
  input wire logic shared_pin_oe
);
  import gate_cfg_pkg::*;
  logic [1:0] rcnt;
  logic [1:0] next_rcnt;
  logic live;
  logic [4:0] cfg_out;
  // Checks start once the reset synchroniser has let go
  always_comb next_rcnt = (rcnt == 2'h3) ? rcnt : rcnt + 2'h1;
  always_ff @(posedge ref_clk or negedge nrst) begin
    if (!nrst) rcnt <= 2'h0;
    else rcnt <= next_rcnt;
  end
  assign live = (rcnt == 2'h3);
  assign cfg_out = {primary_undervolt_enable, primary_undervolt_level, primary_overvolt_enable,
    primary_overvolt_level, primary_temp_warning_enable};
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!live);
  a_reset_values: assert property ($rose(live) |-> cfg_out == 5'h14 &&
    fault_report_config == 16'h0200) else $error("bad reset values");
  a_config_hold: assert property (spi_cs_n [*2] |=> $stable({cfg_out, fault_report_config}))
    else $error("config changed without a frame");
  a_fault_req_pin: assert property (primary_fault_req |=> primary_fault_oe)
    else $error("fault request not on primary pin");
  a_fault_pin_idle: assert property (!primary_fault_req && !secondary_warn_req |=>
    !primary_fault_oe) else $error("primary pin pulled without cause");
  a_shared_pin_idle: assert property (spi_cs_n && !secondary_warn_req |=> !shared_pin_oe)
    else $error("shared pin driven without cause");
  a_gate_off_low: assert property (!pwm_input_pos [*8] ##1 !pwm_input_pos [*3] |-> !gate_on)
    else $error("gate on with input low");
  a_gate_interlock: assert property (pwm_input_neg [*8] ##1 pwm_input_neg [*3] |-> !gate_on)
    else $error("gate on with inverting input high");
  a_gate_turn_on: assert property (!pwm_input_pos [*8] ##1 !pwm_input_pos [*3] ##1
    pwm_input_pos |=> !gate_on) else $error("gate on too early");
endmodule : cfg_checker

bind primary_side_config_regs cfg_checker cfg_checker_inst (
  .ref_clk(ref_clk),
  .nrst(nrst),
  .spi_cs_n(spi_cs_n),
  .pwm_input_pos(pwm_input_pos),
  .pwm_input_neg(pwm_input_neg),
  .primary_fault_req(primary_fault_req),
  .secondary_warn_req(secondary_warn_req),
  .primary_undervolt_enable(primary_undervolt_enable),
  .primary_undervolt_level(primary_undervolt_level),
  .primary_overvolt_enable(primary_overvolt_enable),
  .primary_overvolt_level(primary_overvolt_level),
  .primary_temp_warning_enable(primary_temp_warning_enable),
  .fault_report_config(fault_report_config),
  .gate_on(gate_on),
  .primary_fault_oe(primary_fault_oe),
  .shared_pin_oe(shared_pin_oe)
);

// [bench/serial_host.sv]
// Host model driving the serial configuration port.
// Assumes the device samples the port on ref_clk, mode 0, MSB first.
`timescale 1ns/10ps
module serial_host (
  input wire logic ref_clk,
  input wire logic shared_pin_out,
  input wire logic shared_pin_oe,
  output logic spi_sclk,
  output logic spi_cs_n,
  output logic spi_mosi
);
  import gate_cfg_pkg::*;
  logic dout_wire;
  // Shared pin is pulled up when nobody drives it
  assign dout_wire = shared_pin_oe ? shared_pin_out : 1'b1;
  initial begin
    spi_sclk = 1'b0;
    spi_cs_n = 1'b1;
    spi_mosi = 1'b0;
  end
  task automatic xfer(input logic wr, input logic [6:0] a, input reg_word_t wd,
    output reg_word_t rd);
    logic [23:0] frame;
    frame = {wr, a, wd};
    rd = 16'h0000;
    @(negedge ref_clk);
    spi_cs_n = 1'b0;
    for (int i = 23; i >= 0; i--) begin
      spi_sclk = 1'b0;
      spi_mosi = frame[i];
      repeat (3) @(negedge ref_clk);
      if (i < 16) rd[i] = dout_wire;
      spi_sclk = 1'b1;
      repeat (2) @(negedge ref_clk);
    end
    spi_sclk = 1'b0;
    repeat (2) @(negedge ref_clk);
    spi_cs_n = 1'b1;
    spi_mosi = ~spi_mosi;
    @(negedge ref_clk);
  endtask : xfer
endmodule : serial_host

// [bench/test_primary_side_config_regs.sv]
// Self-checking bench for primary_side_config_regs.
// Assumes serial_host drives the port and cfg_checker is bound.
`timescale 1ns/10ps
`include "gate_cfg_regs.svh"
module test_primary_side_config_regs;
  import gate_cfg_pkg::*;
  logic ref_clk, nrst, sclk, cs_n, mosi, pos, neg, freq, warn;
  logic ue, ul, oe, ol, tw, gate_on, pfo, pfoe, spo, spoe;
  reg_word_t frc, cur, r, v;
  int seed, error_cnt, checks;
  primary_side_config_regs primary_side_config_regs_inst (.ref_clk(ref_clk), .nrst(nrst),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi), .pwm_input_pos(pos),
    .pwm_input_neg(neg), .primary_fault_req(freq), .secondary_warn_req(warn),
    .primary_undervolt_enable(ue), .primary_undervolt_level(ul), .primary_overvolt_enable(oe),
    .primary_overvolt_level(ol), .primary_temp_warning_enable(tw), .fault_report_config(frc),
    .gate_on(gate_on), .primary_fault_out(pfo), .primary_fault_oe(pfoe),
    .shared_pin_out(spo), .shared_pin_oe(spoe));
  serial_host serial_host_inst (.ref_clk(ref_clk), .shared_pin_out(spo), .shared_pin_oe(spoe),
    .spi_sclk(sclk), .spi_cs_n(cs_n), .spi_mosi(mosi));
  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end
  task automatic check(input reg_word_t got, input reg_word_t exp);
    checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check
  task automatic summarize();
    $display("checks=%0d error_cnt=%0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask : summarize
  function automatic reg_word_t outs(input reg_word_t c);
    return {11'h000, ~c[15], c[14], ~c[8], c[13], ~c[10]};
  endfunction : outs
  // Cycles from input rise to gate on: filter, then dead time rounded up
  function automatic int gate_delay(input reg_word_t c);
    int f;
    f = (c[12:11] == 2'h0) ? 1 : (c[12:11] * `DEGLITCH_STEP_NS + 24) / `CLK_PERIOD_NS;
    if (c[5:0] == 6'h00) return f + 1;
    return f + (c[5:0] * `DEAD_STEP_NS + `DEAD_BASE_NS + 24) / `CLK_PERIOD_NS;
  endfunction : gate_delay
  task automatic rd(input logic [6:0] a, input reg_word_t exp);
    serial_host_inst.xfer(1'b0, a, 16'h0000, r);
    check(r, exp);
  endtask : rd
  // Old value comes back only if the shared pin was already data out
  task automatic wr_cfg(input reg_word_t c);
    serial_host_inst.xfer(1'b1, `PRIMARY_CONFIG_ADDR, c, r);
    if (cur[6]) check(r, cur);
    cur = c;
    check({11'h000, ue, ul, oe, ol, tw}, outs(c));
  endtask : wr_cfg
  task automatic fault_scan();
    for (int j = 0; j < 4; j++) begin
      {warn, freq} = 2'(j);
      repeat (2) @(negedge ref_clk);
      check({pfo, pfoe}, {1'b0, freq | (cur[6] & warn)});
      check(spoe, ~cur[6] & warn);
    end
    {warn, freq} = 2'h0;
  endtask : fault_scan
  task automatic pwm_run(input reg_word_t c);
    int n;
    wr_cfg(c);
    pos = 1'b1;
    n = 0;
    while (gate_on !== 1'b1 && n < 300) begin
      @(negedge ref_clk);
      n++;
    end
    if (n == 300) begin
      error_cnt++;
      summarize();
    end
    check(16'(n), 16'(gate_delay(c)));
    pos = 1'b0;
    repeat (12) @(negedge ref_clk);
    check(gate_on, 16'h0000);
  endtask : pwm_run
  initial begin
    seed = 86030;
    {nrst, pos, neg, freq, warn} = 5'h00;
    cur = `PRIMARY_CONFIG_RESET;
    repeat (5) @(negedge ref_clk);
    nrst = 1'b1;
    repeat (3) @(negedge ref_clk);
    check({11'h000, ue, ul, oe, ol, tw}, outs(cur));
    check(frc, `FAULT_REPORT_CONFIG_RESET);
    fault_scan();
    wr_cfg(16'h0c40);
    fault_scan();
    for (int i = 0; i < 6; i++) wr_cfg(16'($random(seed)) | 16'h0040);
    rd(`PRIMARY_CONFIG_ADDR, cur);
    rd(`PRIMARY_CONFIG_ADDR, cur);
    serial_host_inst.xfer(1'b1, 7'h55, 16'hffff, r);
    rd(7'h55, 16'h0000);
    rd(`PRIMARY_CONFIG_ADDR, cur);
    v = 16'($random(seed));
    serial_host_inst.xfer(1'b1, `FAULT_REPORT_CONFIG_ADDR, v, r);
    check(r, `FAULT_REPORT_CONFIG_RESET);
    check(frc, v);
    for (int s = 0; s < 4; s++) begin
      for (int k = 0; k < 3; k++) begin
        v = (k == 2) ? 16'h003f : 16'($random(seed)) & 16'(k * 63);
        pwm_run(v | 16'h0040 | 16'(s << 11));
      end
    end
    wr_cfg(16'h0840);
    pos = 1'b1;
    repeat (2) @(negedge ref_clk);
    pos = 1'b0;
    repeat (8) @(negedge ref_clk);
    check(gate_on, 16'h0000);
    {pos, neg} = 2'h3;
    repeat (20) @(negedge ref_clk);
    check(gate_on, 16'h0000);
    {pos, neg} = 2'h0;
    summarize();
  end
endmodule : test_primary_side_config_regs
